// ---- serial_target.sv ----
// two-wire serial target with pointer, auto increment and open-drain data
module serial_target
   import dbs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // serial pins
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_oe_n,
   // register side
   reg_access_if.target link
);

   typedef enum logic [3:0] {IDLE, ADDR, ACK_ADDR, PTR, ACK_PTR, WRITE, ACK_WRITE, LOAD, READ, ACK_READ} tstate_t;

   tstate_t state_reg, state_next;
   logic scl_reg, sda_reg;
   logic [2:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [7:0] ptr_reg, ptr_next;
   logic rw_reg, rw_next;
   logic ack_slot_reg, ack_slot_next;
   logic acked_reg, acked_next;
   logic drive_n_reg, drive_n_next;
   logic wr_reg, wr_next, rd_reg, rd_next, done_reg, done_next;
   logic scl_rise, scl_fall, start, stop;

   assign scl_rise = scl & ~scl_reg;
   assign scl_fall = ~scl & scl_reg;
   assign start = scl & scl_reg & sda_reg & ~sda_in;
   assign stop = scl & scl_reg & ~sda_reg & sda_in;

   assign sda_oe_n = drive_n_reg;
   assign link.wr_stb = wr_reg;
   assign link.rd_stb = rd_reg;
   assign link.rd_done = done_reg;
   assign link.addr = ptr_reg;
   assign link.wdata = shift_reg;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      shift_next = shift_reg;
      ptr_next = ptr_reg;
      rw_next = rw_reg;
      ack_slot_next = ack_slot_reg;
      acked_next = acked_reg;
      drive_n_next = drive_n_reg;
      wr_next = 1'b0;
      rd_next = 1'b0;
      done_next = 1'b0;
      if (start) begin
         state_next = ADDR;
         cnt_next = 3'd0;
         drive_n_next = 1'b1;
         ack_slot_next = 1'b0;
      end else if (stop) begin
         state_next = IDLE;
         drive_n_next = 1'b1;
      end else begin
         unique case (state_reg)
            IDLE: begin
            end
            ADDR, PTR, WRITE: begin
               if (scl_rise) begin
                  shift_next = {shift_reg[6:0], sda_in};
                  cnt_next = cnt_reg + 3'd1;
                  if (cnt_reg == 3'd7) begin
                     ack_slot_next = 1'b0;
                     if (state_reg == ADDR) begin
                        rw_next = sda_in;
                        state_next = (shift_reg[6:0] == DEV_ADDR) ? ACK_ADDR : IDLE;
                     end else if (state_reg == PTR) begin
                        state_next = ACK_PTR;
                     end else begin
                        state_next = ACK_WRITE;
                     end
                  end
               end
            end
            ACK_ADDR, ACK_PTR, ACK_WRITE: begin
               if (scl_fall && !ack_slot_reg) begin
                  ack_slot_next = 1'b1;
                  drive_n_next = 1'b0;
                  if (state_reg == ACK_PTR) begin
                     ptr_next = shift_reg;
                  end
                  if (state_reg == ACK_WRITE) begin
                     wr_next = 1'b1;
                  end
               end else if (scl_fall) begin
                  ack_slot_next = 1'b0;
                  drive_n_next = 1'b1;
                  if (state_reg == ACK_ADDR && rw_reg) begin
                     rd_next = 1'b1;
                     state_next = LOAD;
                  end else if (state_reg == ACK_ADDR) begin
                     state_next = PTR;
                  end else begin
                     if (state_reg == ACK_WRITE) begin
                        ptr_next = ptr_reg + 8'd1;
                     end
                     state_next = WRITE;
                  end
               end
            end
            LOAD: begin
               if (rd_reg) begin
                  drive_n_next = link.rdata[7];
                  shift_next = {link.rdata[6:0], 1'b0};
                  cnt_next = 3'd0;
                  state_next = READ;
               end
            end
            READ: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + 3'd1;
                  if (cnt_reg == 3'd7) begin
                     ack_slot_next = 1'b0;
                     state_next = ACK_READ;
                  end
               end else if (scl_fall && cnt_reg != 3'd0) begin
                  drive_n_next = shift_reg[7];
                  shift_next = {shift_reg[6:0], 1'b0};
               end
            end
            ACK_READ: begin
               if (scl_fall && !ack_slot_reg) begin
                  drive_n_next = 1'b1;
                  ack_slot_next = 1'b1;
               end else if (scl_rise && ack_slot_reg) begin
                  acked_next = ~sda_in;
                  done_next = 1'b1;
               end else if (scl_fall) begin
                  ack_slot_next = 1'b0;
                  if (acked_reg) begin
                     ptr_next = ptr_reg + 8'd1;
                     rd_next = 1'b1;
                     state_next = LOAD;
                  end else begin
                     state_next = IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= IDLE;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         cnt_reg <= 3'd0;
         shift_reg <= 8'h00;
         ptr_reg <= 8'h00;
         rw_reg <= 1'b0;
         ack_slot_reg <= 1'b0;
         acked_reg <= 1'b0;
         drive_n_reg <= 1'b1;
         wr_reg <= 1'b0;
         rd_reg <= 1'b0;
         done_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         scl_reg <= scl;
         sda_reg <= sda_in;
         cnt_reg <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg <= ptr_next;
         rw_reg <= rw_next;
         ack_slot_reg <= ack_slot_next;
         acked_reg <= acked_next;
         drive_n_reg <= drive_n_next;
         wr_reg <= wr_next;
         rd_reg <= rd_next;
         done_reg <= done_next;
      end
   end

endmodule

// ---- dbs_pkg.sv ----
// shared constants for the dual battery status and interrupt block
package dbs_pkg;

   // register offsets
   localparam logic [7:0] STATE_OFFSET = 8'h00;
   localparam logic [7:0] CONFIG_OFFSET = 8'h01;

   // battery_state field positions
   localparam int ST_SEC_BAND_LSB = 0;
   localparam int ST_PRI_BAND_LSB = 2;
   localparam int ST_SOURCE_LSB = 4;
   localparam int ST_PRI_PRESENT = 6;
   localparam int ST_SEC_PRESENT = 7;

   // configuration_control field positions
   localparam int CFG_CHARGER_OFF = 0;
   localparam int CFG_SEC_FLAG = 1;
   localparam int CFG_MODE_LSB = 2;

   // reset values and unmapped read value
   localparam logic [7:0] CONFIG_RESET = 8'h00;
   localparam logic [7:0] STATE_RESET = 8'h00;
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // serial target address, arbitrary value
   localparam logic [6:0] DEV_ADDR_DEFAULT = 7'h2a;

   // voltage band codes
   localparam logic [1:0] BAND_BELOW_LOWER = 2'b00;
   localparam logic [1:0] BAND_MID = 2'b01;
   localparam logic [1:0] BAND_HIGH = 2'b10;
   localparam logic [1:0] BAND_FULL = 2'b11;

   // comparator levels to a band code
   function automatic logic [1:0] band_code(input logic above_lower, input logic above_upper,
                                            input logic at_full);
      logic [1:0] code;
      code = BAND_BELOW_LOWER;
      if (at_full) begin
         code = BAND_FULL;
      end else if (above_upper) begin
         code = BAND_HIGH;
      end else if (above_lower) begin
         code = BAND_MID;
      end
      return code;
   endfunction

endpackage

// ---- reg_access_if.sv ----
// register access strobes between the serial target and the register file
interface reg_access_if;
   logic wr_stb;
   logic rd_stb;
   logic rd_done;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;

   modport target (output wr_stb, output rd_stb, output rd_done, output addr, output wdata, input rdata);
   modport regs (input wr_stb, input rd_stb, input rd_done, input addr, input wdata, output rdata);
endinterface

// ---- status_monitor.sv ----
// live battery state byte, charge flags and change detection
module status_monitor
   import dbs_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_n,
   // comparator levels
   input wire logic pri_above_lower,
   input wire logic pri_above_upper,
   input wire logic pri_at_full,
   input wire logic sec_above_lower,
   input wire logic sec_above_upper,
   input wire logic sec_at_full,
   // path and charger state
   input wire logic [1:0] supply_source,
   input wire logic primary_present,
   input wire logic secondary_present,
   input wire logic charging_primary,
   input wire logic charging_secondary,
   input wire logic charger_off,
   // results
   output logic [7:0] state_byte,
   output logic primary_charge_flag,
   output logic secondary_charge_flag,
   output logic status_change
);

   logic [7:0] state_reg, state_next;
   logic pri_flag_reg, pri_flag_next, sec_flag_reg, sec_flag_next;
   logic change_reg, change_next;

   assign state_byte = state_reg;
   assign primary_charge_flag = pri_flag_reg;
   assign secondary_charge_flag = sec_flag_reg;
   assign status_change = change_reg;

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      state_next = STATE_RESET;
      state_next[ST_PRI_BAND_LSB +: 2] = band_code(pri_above_lower, pri_above_upper, pri_at_full); // RULE1
      state_next[ST_SEC_BAND_LSB +: 2] = band_code(sec_above_lower, sec_above_upper, sec_at_full);
      state_next[ST_SOURCE_LSB +: 2] = supply_source;
      state_next[ST_PRI_PRESENT] = primary_present;
      state_next[ST_SEC_PRESENT] = secondary_present;
      pri_flag_next = charger_off | ~charging_primary; // RULE2 RULE5
      sec_flag_next = charger_off | ~charging_secondary; // RULE3 RULE5
      change_next = (state_next != state_reg); // RULE8 RULE11
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         state_reg <= STATE_RESET;
         pri_flag_reg <= 1'b1;
         sec_flag_reg <= 1'b1;
         change_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         pri_flag_reg <= pri_flag_next;
         sec_flag_reg <= sec_flag_next;
         change_reg <= change_next;
      end
   end

endmodule

// ---- dual_battery_status_irq.sv ----
// register file and latching interrupt of the dual battery controller
//
// Behaviour
// RULE1: primary band coded 00, 01, 10, 11
// RULE2: primary flag 0 only while charging primary
// RULE3: secondary flag 0 only while charging secondary
// RULE4: config bit writes charger-off, reads primary flag
// RULE5: charger-off disables charger, both flags 1
// RULE6: interrupt latches at status change until cleared
// RULE7: interrupt always asserted after power-up
// RULE8: each later status change asserts interrupt
// RULE9: state register read returns live status
// RULE10: host reads state and clears interrupt
// RULE11: supply removal switches battery, asserts interrupt
// RULE12: reset pin low restores defaults, restarts startup
// RULE13: only a completed state read clears interrupt
module dual_battery_status_irq
   import dbs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // clock and resets
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hw_reset_n,
   // serial pins
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe_n,
   // primary battery comparators
   input wire logic pri_above_lower,
   input wire logic pri_above_upper,
   input wire logic pri_at_full,
   // secondary battery comparators
   input wire logic sec_above_lower,
   input wire logic sec_above_upper,
   input wire logic sec_at_full,
   // power path and charger
   input wire logic [1:0] supply_source,
   input wire logic primary_present,
   input wire logic secondary_present,
   input wire logic charging_primary,
   input wire logic charging_secondary,
   output logic charger_off,
   output logic [5:0] mode_bits,
   // interrupt
   output logic status_irq_n
);

   logic rst_n;
   logic [7:0] state_byte;
   logic pri_flag, sec_flag, status_change;
   logic [7:0] config_reg, config_next;
   logic irq_n_reg, irq_n_next;
   logic sda_out_reg;
   logic state_read_done;

   reg_access_if link ();

   assign rst_n = resetn & hw_reset_n; // RULE12

   ////////////////////////////////////////////////////////////////////////////////
   serial_target #(
      .DEV_ADDR(DEV_ADDR)
   ) u_target (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .scl(scl),
      .sda_in(sda_in),
      .sda_oe_n(sda_oe_n),
      .link(link.target)
   );

   status_monitor u_monitor (
      .ref_clk(ref_clk),
      .rst_n(rst_n),
      .pri_above_lower(pri_above_lower),
      .pri_above_upper(pri_above_upper),
      .pri_at_full(pri_at_full),
      .sec_above_lower(sec_above_lower),
      .sec_above_upper(sec_above_upper),
      .sec_at_full(sec_at_full),
      .supply_source(supply_source),
      .primary_present(primary_present),
      .secondary_present(secondary_present),
      .charging_primary(charging_primary),
      .charging_secondary(charging_secondary),
      .charger_off(config_reg[CFG_CHARGER_OFF]),
      .state_byte(state_byte),
      .primary_charge_flag(pri_flag),
      .secondary_charge_flag(sec_flag),
      .status_change(status_change)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      link.rdata = UNMAPPED_READ;
      if (link.addr == STATE_OFFSET) begin
         link.rdata = state_byte; // RULE9
      end else if (link.addr == CONFIG_OFFSET) begin
         link.rdata = config_reg;
         link.rdata[CFG_CHARGER_OFF] = pri_flag; // RULE4
         link.rdata[CFG_SEC_FLAG] = sec_flag;
      end
   end

   assign state_read_done = link.rd_done & (link.addr == STATE_OFFSET);

   ////////////////////////////////////////////////////////////////////////////////
   // configuration and interrupt latch
   always_comb begin
      config_next = config_reg;
      if (link.wr_stb && link.addr == CONFIG_OFFSET) begin
         config_next = link.wdata; // RULE4 RULE5
         config_next[CFG_SEC_FLAG] = 1'b0;
      end
      irq_n_next = ~status_change & (irq_n_reg | state_read_done); // RULE6 RULE8 RULE11 RULE13 RULE10
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_n) begin
         config_reg <= CONFIG_RESET;
         irq_n_reg <= 1'b0; // RULE7 RULE12
         sda_out_reg <= 1'b0;
      end else begin
         config_reg <= config_next;
         irq_n_reg <= irq_n_next;
         sda_out_reg <= 1'b0;
      end
   end

   assign status_irq_n = irq_n_reg;
   assign charger_off = config_reg[CFG_CHARGER_OFF];
   assign mode_bits = config_reg[7:CFG_MODE_LSB];
   assign sda_out = sda_out_reg;

endmodule

// ---- dbs_host_master.sv ----
// serial master model of the host processor
module dbs_host_master
   import dbs_pkg::*;
#(
   parameter logic [6:0] DEV_ADDR = DEV_ADDR_DEFAULT
) (
   // clock
   input wire logic ref_clk,
   // serial pins
   output logic scl,
   output logic sda_n,
   input wire logic sda
);
   timeunit 1ns;
   timeprecision 100ps;
   initial begin
      scl = 1'b1;
      sda_n = 1'b1;
   end
   task automatic half();
      repeat (8) @(negedge ref_clk);
   endtask
   task automatic start();
      half();
      sda_n = 1'b1;
      half();
      scl = 1'b1;
      half();
      sda_n = 1'b0;
      half();
      scl = 1'b0;
   endtask
   task automatic stop();
      half();
      sda_n = 1'b0;
      half();
      scl = 1'b1;
      half();
      sda_n = 1'b1;
      half();
   endtask
   task automatic clk_bit(input logic b, output logic seen);
      repeat (2) @(negedge ref_clk);
      sda_n = b;
      half();
      scl = 1'b1;
      half();
      seen = sda;
      scl = 1'b0;
   endtask
   task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
      for (int i = 7; i >= 0; i--) begin
         clk_bit(tx[i], rx[i]);
      end
   endtask
   task automatic send(input logic [7:0] b, inout logic ok);
      logic [7:0] x;
      logic k;
      xfer(b, x);
      clk_bit(1'b1, k);
      ok = ok & ~k;
   endtask
   task automatic reg_write(input logic [7:0] a, input logic [7:0] d, output logic ok);
      ok = 1'b1;
      start();
      send({DEV_ADDR, 1'b0}, ok);
      send(a, ok);
      send(d, ok);
      stop();
   endtask
   // pointer write, repeated start, one byte, nack
   task automatic reg_read(input logic [7:0] a, output logic [7:0] d, output logic ok);
      logic k;
      ok = 1'b1;
      start();
      send({DEV_ADDR, 1'b0}, ok);
      send(a, ok);
      start();
      send({DEV_ADDR, 1'b1}, ok);
      xfer(8'hff, d);
      clk_bit(1'b1, k);
      stop();
   endtask
endmodule

// ---- dbs_checker_sva.sv ----
// port assertions for the dual battery status block
module dbs_checker (
   // clock and resets
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic hw_reset_n,
   // serial pins
   input wire logic scl,
   input wire logic sda_out,
   input wire logic sda_oe_n,
   // comparators
   input wire logic pri_above_lower,
   input wire logic pri_above_upper,
   input wire logic pri_at_full,
   input wire logic sec_above_lower,
   input wire logic sec_above_upper,
   input wire logic sec_at_full,
   // path and charger
   input wire logic [1:0] supply_source,
   input wire logic primary_present,
   input wire logic secondary_present,
   input wire logic charger_off,
   input wire logic [5:0] mode_bits,
   // interrupt
   input wire logic status_irq_n
);
   timeunit 1ns;
   timeprecision 100ps;
   function automatic logic [1:0] bnd(input logic l, input logic u, input logic f);
      return f ? 2'b11 : (u ? 2'b10 : {1'b0, l});
   endfunction
   logic [7:0] live_st;
   logic run;
   assign run = resetn & hw_reset_n;
   assign live_st = {secondary_present, primary_present, supply_source,
      bnd(pri_above_lower, pri_above_upper, pri_at_full), bnd(sec_above_lower, sec_above_upper, sec_at_full)};
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!run);
   ////////////////////////////////////////////////////////////////////////////
   sequence s_status_change;
      live_st != $past(live_st);
   endsequence
   sequence s_irq_set;
      ##[1:2] !status_irq_n;
   endsequence
   a_reset_defaults: assert property (disable iff (1'b0)
      !run |=> !status_irq_n && !charger_off && mode_bits == 6'h00 && sda_oe_n)
      else $error("defaults missing in reset");
   a_startup_irq_held: assert property ($rose(run) |-> !status_irq_n [*3])
      else $error("irq not held after startup");
   a_change_sets_irq: assert property (s_status_change |-> s_irq_set)
      else $error("status change missed");
   a_irq_stays_latched: assert property (!status_irq_n && !scl |=> !status_irq_n)
      else $error("irq dropped while scl low");
   a_clear_at_ack: assert property ($rose(status_irq_n) |-> scl && $past(scl))
      else $error("irq cleared outside ack bit");
   a_cfg_scl_low: assert property ($changed({charger_off, mode_bits}) |-> !scl)
      else $error("config changed while scl high");
   a_sda_out_low: assert property (sda_out == 1'b0)
      else $error("sda_out not low");
   a_oe_scl_low: assert property ($changed(sda_oe_n) |-> !scl)
      else $error("sda changed while scl high");
endmodule
bind dual_battery_status_irq dbs_checker chk_u (.ref_clk, .resetn, .hw_reset_n, .scl, .sda_out, .sda_oe_n,
   .pri_above_lower, .pri_above_upper, .pri_at_full, .sec_above_lower, .sec_above_upper, .sec_at_full,
   .supply_source, .primary_present, .secondary_present, .charger_off, .mode_bits, .status_irq_n);

// ---- tb_dual_battery_status_irq.sv ----
// self-checking bench for the dual battery status block
module tb_dual_battery_status_irq;
   timeunit 1ns;
   timeprecision 100ps;
   import dbs_pkg::*;
   localparam logic [2:0] LUT [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic hw_reset_n = 1'b1;
   logic pri_above_lower = 1'b1, pri_above_upper = 1'b1, pri_at_full = 1'b0;
   logic sec_above_lower = 1'b1, sec_above_upper = 1'b0, sec_at_full = 1'b0;
   logic [1:0] supply_source = 2'b00;
   logic primary_present = 1'b1, secondary_present = 1'b1;
   logic charging_primary = 1'b0, charging_secondary = 1'b0;
   logic [1:0] pri_band = 2'b10, sec_band = 2'b01;
   logic scl, host_sda_n, sda_out, sda_oe_n, charger_off, status_irq_n, ok;
   logic [5:0] mode_bits;
   logic [7:0] rd;
   int mismatches = 0, n_compared = 0;
   wire logic sda_w = sda_oe_n & host_sda_n;
   always #5 ref_clk = ~ref_clk;
   dual_battery_status_irq dut_u (.ref_clk, .resetn, .hw_reset_n, .scl, .sda_in(sda_w), .sda_out, .sda_oe_n,
      .pri_above_lower, .pri_above_upper, .pri_at_full, .sec_above_lower, .sec_above_upper, .sec_at_full,
      .supply_source, .primary_present, .secondary_present, .charging_primary, .charging_secondary,
      .charger_off, .mode_bits, .status_irq_n);
   dbs_host_master host_u (.ref_clk, .scl, .sda_n(host_sda_n), .sda(sda_w));
   ////////////////////////////////////////////////////////////////////////////
   task automatic complete_run();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(negedge ref_clk);
   endtask
   task automatic irq_low();
      check({7'h00, status_irq_n}, 8'h00);
   endtask
   task automatic read_state_check();
      host_u.reg_read(STATE_OFFSET, rd, ok);
      check({7'h00, ok}, 8'h01);
      check(rd, {secondary_present, primary_present, supply_source, pri_band, sec_band});
      check({7'h00, status_irq_n}, 8'h01);
   endtask
   task automatic cfg_check(input logic [7:0] exp);
      host_u.reg_read(CONFIG_OFFSET, rd, ok);
      check(rd, exp);
   endtask
   task automatic t_bands();
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         pri_band = 2'(i);
         sec_band = 2'(3 - i);
         {pri_above_lower, pri_above_upper, pri_at_full} = LUT[pri_band];
         {sec_above_lower, sec_above_upper, sec_at_full} = LUT[sec_band];
         wait_n(4);
         irq_low();
         read_state_check();
      end
   endtask
   task automatic t_flags();
      for (int i = 0; i < 4; i++) begin
         @(negedge ref_clk);
         {charging_secondary, charging_primary} = 2'(i);
         wait_n(4);
         cfg_check({6'h00, ~charging_secondary, ~charging_primary});
      end
      host_u.reg_write(CONFIG_OFFSET, 8'h05, ok);
      check({1'b0, charger_off, mode_bits}, 8'h41);
      cfg_check(8'h07);
      host_u.reg_write(CONFIG_OFFSET, 8'h00, ok);
      cfg_check(8'h00);
   endtask
   task automatic t_hotswap();
      @(negedge ref_clk);
      supply_source = 2'b01;
      primary_present = 1'b0;
      wait_n(4);
      irq_low();
      read_state_check();
      @(negedge ref_clk);
      supply_source = 2'b00;
      primary_present = 1'b1;
      wait_n(4);
      host_u.reg_write(STATE_OFFSET, 8'hff, ok);
      cfg_check(8'h00);
      irq_low();
      host_u.reg_read(8'h05, rd, ok);
      check(rd, UNMAPPED_READ);
      read_state_check();
   endtask
   task automatic t_hwreset();
      host_u.reg_write(CONFIG_OFFSET, 8'h05, ok);
      @(negedge ref_clk);
      hw_reset_n = 1'b0;
      wait_n(4);
      check({1'b0, charger_off, mode_bits}, 8'h00);
      irq_low();
      hw_reset_n = 1'b1;
      wait_n(4);
      irq_low();
      read_state_check();
      cfg_check(8'h00);
   endtask
   initial begin
      repeat (100000) @(posedge ref_clk);
      mismatches++;
      complete_run();
   end
   task automatic t_startup();
      wait_n(16);
      resetn = 1'b1;
      wait_n(4);
      irq_low();
      read_state_check();
   endtask
   initial begin
      t_startup();
      t_bands();
      t_flags();
      t_hotswap();
      t_hwreset();
      complete_run();
   end
endmodule
